// *** hw/epm_pkg.sv ***
// Constants, register map and mode type of the encoder power-mode block.
// Assumes a 100 MHz core clock; all cycle counts derive from it.
package epm_pkg;
  localparam int CLK_HZ = 100000000;
  localparam int CLK_NS = 10;
  // Serial frame and command codes
  localparam int         FRAME_BITS = 21;
  localparam int         CMD_BITS   = 5;
  localparam logic [4:0] CMD_READ   = 5'h00;
  localparam logic [4:0] CMD_PWR    = 5'h11;
  localparam logic [4:0] CMD_RST    = 5'h15;
  // Converter tracking step and analog path delay
  localparam int TRACK_NS      = 1150;
  localparam int TRACK_CYC     = (TRACK_NS + CLK_NS - 1) / CLK_NS;
  localparam int ANALOG_NS     = 15600;
  localparam int ANALOG_STAGES = ANALOG_NS / TRACK_NS;
  // Cold start and wake-up times
  localparam int COLD_ACT_NS  = 1000000;
  localparam int COLD_AGC_NS  = 3800000;
  localparam int WAKE_LP_NS   = 150000;
  localparam int WAKE_ULP_NS  = 500000;
  localparam int COLD_ACT_CYC = (COLD_ACT_NS + CLK_NS - 1) / CLK_NS;
  localparam int COLD_AGC_CYC = (COLD_AGC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_LP_CYC  = (WAKE_LP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_ULP_CYC = (WAKE_ULP_NS + CLK_NS - 1) / CLK_NS;
  // Pulse-width output
  localparam int PWM_HZ       = 1950;
  localparam int PWM_CYC      = CLK_HZ / PWM_HZ;
  localparam int PWM_STEP_NS  = 2000;
  localparam int PWM_STEP_CYC = PWM_STEP_NS / CLK_NS;
  // Register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_ANGLE = 8'h08;
  localparam logic [7:0] A_ISTAT = 8'h0c;
  localparam logic [7:0] A_IMASK = 8'h10;
  // Control fields
  localparam int         C_PS    = 0;
  localparam int         C_DS    = 1;
  localparam int         C_DBOFF = 2;
  localparam int         C_RST   = 3;
  localparam logic [3:0] CTRL_RV = 4'h0;
  // Interrupt status bits
  localparam int         IRQ_W      = 4;
  localparam int         I_LOCK     = 0;
  localparam int         I_WAKE     = 1;
  localparam int         I_CMD      = 2;
  localparam int         I_SETTLE   = 3;
  localparam logic [3:0] IMASK_RV   = 4'h0;
  typedef enum logic [1:0] {EPM_NORMAL, EPM_LOW, EPM_ULTRA} epm_mode_t;
endpackage

// *** hw/epm_tracker.sv ***
// Tracking angle converter with analog delay line and output dead band.
// Assumes tick is a one-cycle strobe once per tracking step.
`timescale 1ns/100ps
`default_nettype none
module epm_tracker #(
  parameter int STAGES = epm_pkg::ANALOG_STAGES
) (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       tick,
  input  wire logic       run,
  input  wire logic       clr,
  input  wire logic       hys_en,
  input  wire logic [7:0] sense,
  output logic      [7:0] angle,
  output logic            lock
);
  logic [7:0] line_reg [STAGES];
  logic [7:0] pos_reg;
  logic [7:0] out_reg;
  logic       dir_reg;
  logic       lock_reg;
  wire        step = run & tick;
  wire  [7:0] diff = line_reg[STAGES-1] - pos_reg;
  wire  [7:0] odiff = pos_reg - out_reg;
  wire  [7:0] omag = odiff[7] ? 8'h00 - odiff : odiff;
  wire        odir = ~odiff[7];
  wire        take = (odiff != 8'h00) & (~hys_en | (omag > 8'h01) | (odir == dir_reg));

  // Analog path delay, frozen while not running
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < STAGES; i++) line_reg[i] <= 8'h00;
    end else if (step) begin
      line_reg[0] <= sense;
      for (int i = 1; i < STAGES; i++) line_reg[i] <= line_reg[i-1];
    end
  end

  // One step per tick toward the delayed angle, shortest way round
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pos_reg  <= 8'h00;
      lock_reg <= 1'b0;
    end else if (step) begin
      lock_reg <= (diff == 8'h00);
      if (diff != 8'h00) pos_reg <= diff[7] ? pos_reg - 8'h01 : pos_reg + 8'h01;
    end
  end

  // Output with optional one-step dead band on direction reversal
  always_ff @(posedge core_clk) begin
    if (!reset_n || clr) begin
      out_reg <= pos_reg;
      dir_reg <= 1'b0;
    end else if (take) begin
      out_reg <= pos_reg;
      dir_reg <= odir;
    end
  end

  assign angle = out_reg;
  assign lock  = lock_reg;
endmodule
`default_nettype wire

// *** hw/epm_top.sv ***
// Power-mode control, serial command port, readout and PWM of the encoder.
// Assumes APB master on core_clk; link pins and sensor codes are asynchronous.
//
// How it works
// - Serial command 0x11 is decoded and its mode bits applied.
// - Power-save 0 is normal; 1 selects low or deep sleep by select bit.
// - Dead-band-off 0 gives one step output hysteresis; 1 gives none.
// - Reduced power freezes angle, gain and converter; resume from there.
// - Cold start takes 1.0 ms to activity and 3.8 ms to gain settle.
// - PWM period 1.95 kHz, each angle step adds 2 us pulse width.
// - Serial clock up to 6 MHz; a frame is 21 bits.
// - Output angle lags the field by analog delay plus one step.
// - Valid flag is low while the converter is unlocked.
// - On resume the converter steps one per 1.15 us until matched.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module epm_top #(
  parameter int COLD_ACT_CYC = epm_pkg::COLD_ACT_CYC,
  parameter int COLD_AGC_CYC = epm_pkg::COLD_AGC_CYC,
  parameter int WAKE_LP_CYC  = epm_pkg::WAKE_LP_CYC,
  parameter int WAKE_ULP_CYC = epm_pkg::WAKE_ULP_CYC,
  parameter int PWM_CYC      = epm_pkg::PWM_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        link_clk,
  input  wire logic        link_cs,
  input  wire logic        link_din,
  output logic             link_dout,
  output logic             link_doe,
  input  wire logic [7:0]  sense_angle,
  input  wire logic [5:0]  sense_gain,
  output logic             pwm_out,
  output logic             angle_valid,
  output logic             irq
);
  // Synchronisers
  logic [2:0]  lclk_sync_reg;
  logic [2:0]  lcs_sync_reg;
  logic [1:0]  ldin_sync_reg;
  logic [7:0]  ang_s1_reg;
  logic [7:0]  ang_s2_reg;
  logic [5:0]  gain_s1_reg;
  logic [5:0]  gain_s2_reg;
  logic [7:0]  ang_s3_reg;
  logic [7:0]  ang_use_reg;
  logic [5:0]  gain_s3_reg;
  logic [5:0]  gain_use_reg;
  // Serial port
  logic [20:0] shift_reg;
  logic [4:0]  bits_reg;
  logic [15:0] out_sr_reg;
  logic        dout_reg;
  logic        doe_reg;
  // Control and state
  logic [3:0]  ctrl_reg;
  logic [3:0]  ctrl_next;
  epm_pkg::epm_mode_t mode_reg;
  logic [15:0] wake_reg;
  logic [18:0] cold_reg;
  logic [6:0]  tick_reg;
  logic [5:0]  gain_reg;
  logic [15:0] pwm_cnt_reg;
  logic        pwm_reg;
  logic        valid_reg;
  logic        awake_reg;
  logic        settled_reg;
  // Bus and interrupts
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [3:0]  istat_reg;
  logic [3:0]  imask_reg;
  logic        irq_reg;
  logic [7:0]  trk_angle;
  logic        trk_lock;

  // Two flip-flops ahead of every asynchronous input
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lclk_sync_reg <= 3'h0;
      lcs_sync_reg  <= 3'h0;
      ldin_sync_reg <= 2'h0;
      ang_s1_reg    <= 8'h00;
      ang_s2_reg    <= 8'h00;
      gain_s1_reg   <= 6'h00;
      gain_s2_reg   <= 6'h00;
    end else begin
      lclk_sync_reg <= {lclk_sync_reg[1:0], link_clk};
      lcs_sync_reg  <= {lcs_sync_reg[1:0], link_cs};
      ldin_sync_reg <= {ldin_sync_reg[0], link_din};
      ang_s1_reg    <= sense_angle;
      ang_s2_reg    <= ang_s1_reg;
      gain_s1_reg   <= sense_gain;
      gain_s2_reg   <= gain_s1_reg;
    end
  end

  // Multi-bit sensor codes taken only once two synced samples agree
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ang_s3_reg   <= 8'h00;
      ang_use_reg  <= 8'h00;
      gain_s3_reg  <= 6'h00;
      gain_use_reg <= 6'h00;
    end else begin
      ang_s3_reg  <= ang_s2_reg;
      gain_s3_reg <= gain_s2_reg;
      if (ang_s2_reg == ang_s3_reg) ang_use_reg <= ang_s2_reg;
      if (gain_s2_reg == gain_s3_reg) gain_use_reg <= gain_s2_reg;
    end
  end

  // Link edges, taken only from the second and third stages
  wire lclk_rise  = lclk_sync_reg[1] & ~lclk_sync_reg[2];
  wire lclk_fall  = ~lclk_sync_reg[1] & lclk_sync_reg[2];
  wire cs_on      = lcs_sync_reg[1];
  wire cs_end     = ~lcs_sync_reg[1] & lcs_sync_reg[2];
  wire frame_done = cs_end & (bits_reg == 5'(epm_pkg::FRAME_BITS));
  wire [4:0]  f_cmd  = shift_reg[20:16];
  wire [15:0] f_data = shift_reg[15:0];
  wire pwr_cmd = frame_done & (f_cmd == epm_pkg::CMD_PWR);
  wire rst_cmd = frame_done & (f_cmd == epm_pkg::CMD_RST);
  wire rd_start = (bits_reg == 5'(epm_pkg::CMD_BITS))
                & (shift_reg[4:0] == epm_pkg::CMD_READ) & ~doe_reg;
  wire [15:0] rd_word = {trk_angle, gain_reg, valid_reg, settled_reg};

  // Frame receiver, independent of power mode
  always_ff @(posedge core_clk) begin
    if (!reset_n || !cs_on) begin
      bits_reg <= 5'h00;
    end else if (lclk_rise && bits_reg != 5'(epm_pkg::FRAME_BITS)) begin
      bits_reg <= bits_reg + 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      shift_reg <= 21'h000000;
    end else if (cs_on && lclk_rise) begin
      shift_reg <= {shift_reg[19:0], ldin_sync_reg[1]};
    end
  end

  // Readout shifter, changes data on the falling link edge
  always_ff @(posedge core_clk) begin
    if (!reset_n || !cs_on) begin
      out_sr_reg <= 16'h0000;
      dout_reg   <= 1'b0;
      doe_reg    <= 1'b0;
    end else if (lclk_fall && rd_start) begin
      out_sr_reg <= {rd_word[14:0], 1'b0};
      dout_reg   <= rd_word[15];
      doe_reg    <= 1'b1;
    end else if (lclk_fall && doe_reg) begin
      out_sr_reg <= {out_sr_reg[14:0], 1'b0};
      dout_reg   <= out_sr_reg[15];
    end
  end

  // APB decode
  wire setup   = psel & ~penable;
  wire access  = psel & penable & pready_reg;
  wire hit     = (paddr == epm_pkg::A_CTRL) | (paddr == epm_pkg::A_STAT)
               | (paddr == epm_pkg::A_ANGLE) | (paddr == epm_pkg::A_ISTAT)
               | (paddr == epm_pkg::A_IMASK);
  wire wr_ok   = access & pwrite & hit;
  wire wr_ctrl = wr_ok & (paddr == epm_pkg::A_CTRL);
  wire wr_mask = wr_ok & (paddr == epm_pkg::A_IMASK);
  wire rd_stat = access & ~pwrite & (paddr == epm_pkg::A_ISTAT);

  // Control bits from software or serial commands; serial lands last
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) ctrl_next = pwdata[3:0];
    if (pwr_cmd) begin
      ctrl_next[epm_pkg::C_PS] = f_data[0];
      ctrl_next[epm_pkg::C_DS] = f_data[1];
    end
    if (rst_cmd) begin
      ctrl_next[epm_pkg::C_RST]   = f_data[0];
      ctrl_next[epm_pkg::C_DBOFF] = f_data[1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) ctrl_reg <= epm_pkg::CTRL_RV;
    else          ctrl_reg <= ctrl_next;
  end

  // Mode selection and wake-up delay
  wire ps = ctrl_reg[epm_pkg::C_PS];
  wire ds = ctrl_reg[epm_pkg::C_DS];
  wire wake_edge = (mode_reg != epm_pkg::EPM_NORMAL) & ~ps;
  wire cold_act  = cold_reg >= 19'(COLD_ACT_CYC);
  wire awake     = ~ps & ~wake_edge & cold_act & (wake_reg == 16'h0000);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mode_reg <= epm_pkg::EPM_NORMAL;
      wake_reg <= 16'h0000;
    end else begin
      if (!ps) mode_reg <= epm_pkg::EPM_NORMAL;
      else if (ds) mode_reg <= epm_pkg::EPM_ULTRA;
      else mode_reg <= epm_pkg::EPM_LOW;
      if (wake_edge)
        wake_reg <= (mode_reg == epm_pkg::EPM_ULTRA) ? 16'(WAKE_ULP_CYC - 1)
                                                     : 16'(WAKE_LP_CYC - 1);
      else if (wake_reg != 16'h0000)
        wake_reg <= wake_reg - 16'h0001;
    end
  end

  // Cold start timer from reset release
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cold_reg <= 19'h00000;
    end else if (cold_reg != 19'(COLD_AGC_CYC)) begin
      cold_reg <= cold_reg + 19'h00001;
    end
  end

  // Tracking step strobe
  wire tick = (tick_reg == 7'(epm_pkg::TRACK_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (!reset_n || tick) tick_reg <= 7'h00;
    else                  tick_reg <= tick_reg + 7'h01;
  end

  // Gain regulation, held while asleep
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      gain_reg <= 6'h00;
    end else if (awake && tick && gain_reg != gain_use_reg) begin
      gain_reg <= (gain_reg < gain_use_reg) ? gain_reg + 6'h01 : gain_reg - 6'h01;
    end
  end

  epm_tracker #(
    .STAGES (epm_pkg::ANALOG_STAGES)
  ) u_tracker (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tick     (tick),
    .run      (awake),
    .clr      (ctrl_reg[epm_pkg::C_RST]),
    .hys_en   (~ctrl_reg[epm_pkg::C_DBOFF]),
    .sense    (ang_use_reg),
    .angle    (trk_angle),
    .lock     (trk_lock)
  );

  // Status flags
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      valid_reg   <= 1'b0;
      awake_reg   <= 1'b0;
      settled_reg <= 1'b0;
    end else begin
      valid_reg   <= trk_lock & awake;
      awake_reg   <= awake;
      settled_reg <= cold_reg == 19'(COLD_AGC_CYC);
    end
  end

  // PWM: pulse of (angle + 1) steps in each period
  wire [15:0] pwm_len = 16'(({8'h00, trk_angle} + 16'h0001) * 16'(epm_pkg::PWM_STEP_CYC));

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pwm_cnt_reg <= 16'h0000;
      pwm_reg     <= 1'b0;
    end else begin
      pwm_cnt_reg <= (pwm_cnt_reg == 16'(PWM_CYC - 1)) ? 16'h0000 : pwm_cnt_reg + 16'h0001;
      pwm_reg     <= pwm_cnt_reg < pwm_len;
    end
  end

  // Sticky events; a new event wins over the read clear
  wire [3:0] ev;
  assign ev[epm_pkg::I_LOCK]   = trk_lock & awake & ~valid_reg;
  assign ev[epm_pkg::I_WAKE]   = awake & ~awake_reg;
  assign ev[epm_pkg::I_CMD]    = frame_done;
  assign ev[epm_pkg::I_SETTLE] = (cold_reg == 19'(COLD_AGC_CYC)) & ~settled_reg;
  wire [3:0] iclr = rd_stat ? prdata_reg[3:0] : 4'h0;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      istat_reg <= 4'h0;
      imask_reg <= epm_pkg::IMASK_RV;
      irq_reg   <= 1'b0;
    end else begin
      istat_reg <= (istat_reg & ~iclr) | ev;
      if (wr_mask) imask_reg <= pwdata[3:0];
      irq_reg   <= |(istat_reg & imask_reg);
    end
  end

  // Read mux, sampled in the setup phase
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (paddr)
      epm_pkg::A_CTRL:  rd_mux = {28'h0000000, ctrl_reg};
      epm_pkg::A_STAT:  rd_mux = {26'h0000000, mode_reg, settled_reg, cold_act,
                                  awake_reg, valid_reg};
      epm_pkg::A_ANGLE: rd_mux = {18'h00000, gain_reg, trk_angle};
      epm_pkg::A_ISTAT: rd_mux = {28'h0000000, istat_reg};
      epm_pkg::A_IMASK: rd_mux = {28'h0000000, imask_reg};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // Zero-wait slave: data and error are ready at the access phase
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      if (setup) begin
        prdata_reg  <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_reg <= ~hit;
      end
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign link_dout   = dout_reg;
  assign link_doe    = doe_reg;
  assign pwm_out     = pwm_reg;
  assign angle_valid = valid_reg;
  assign irq         = irq_reg;
endmodule
`default_nettype wire

// *** sim/epm_properties.sv ***
// Port checks for the encoder power-mode block.
// Assumes bind into epm_top, one core_clk domain.
`timescale 1ns/100ps
`default_nettype none
module epm_properties #(
  parameter int COLD_ACT_CYC = epm_pkg::COLD_ACT_CYC,
  parameter int WAKE_LP_CYC  = epm_pkg::WAKE_LP_CYC,
  parameter int PWM_CYC      = epm_pkg::PWM_CYC
) (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        link_cs,
  input wire logic        link_doe,
  input wire logic        pwm_out,
  input wire logic        angle_valid,
  input wire logic        irq
);
  logic [31:0] up_cnt, wk_cnt, pw_cnt;
  logic        ps_q, woke, mask_any, pw_q;
  // Decoded APB writes and map
  wire ctrl_wr  = psel && penable && pwrite && paddr == epm_pkg::A_CTRL;
  wire mask_wr  = psel && penable && pwrite && paddr == epm_pkg::A_IMASK;
  wire unmapped = paddr > epm_pkg::A_IMASK || paddr[1:0] != 2'h0;
  // Time since release and since the last wake write
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      up_cnt <= 32'h0;
      wk_cnt <= 32'h0;
    end else begin
      up_cnt <= up_cnt + 32'h1;
      wk_cnt <= (ctrl_wr && ps_q && !pwdata[0]) ? 32'h0 : wk_cnt + 32'h1;
    end
  end
  // Power-save and mask state as written over APB
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ps_q     <= 1'b0;
      woke     <= 1'b0;
      mask_any <= 1'b0;
    end else begin
      if (ctrl_wr) ps_q <= pwdata[0];
      if (ctrl_wr) woke <= ps_q && !pwdata[0];
      if (mask_wr) mask_any <= |pwdata[3:0];
    end
  end
  // Cycles since the last rise of the pulse output
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pw_q   <= 1'b0;
      pw_cnt <= 32'h0;
    end else begin
      pw_q <= pwm_out;
      if (pwm_out && !pw_q) pw_cnt <= 32'h1;
      else if (pw_cnt != 32'h0) pw_cnt <= pw_cnt + 32'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  cold_valid_a: assert property (angle_valid |-> up_cnt + 32'd2 >= COLD_ACT_CYC)
    else $error("valid before cold start");
  sleep_drop_a: assert property (ctrl_wr && pwdata[0] |-> ##[1:4] !angle_valid)
    else $error("valid kept in reduced power");
  wake_delay_a: assert property ($rose(angle_valid) && woke |-> wk_cnt >= WAKE_LP_CYC)
    else $error("valid before wake time");
  pwm_period_a: assert property ($rose(pwm_out) && pw_cnt != 0 |-> pw_cnt % PWM_CYC == 0)
    else $error("pulse period wrong");
  irq_mask_a: assert property (!mask_any [*2] |-> !irq)
    else $error("interrupt while all masked");
  ready_high_a: assert property ($past(reset_n) |-> pready)
    else $error("ready low");
  slverr_map_a: assert property (psel && penable |-> pslverr == unmapped)
    else $error("slave error wrong");
  doe_release_a: assert property (!link_cs [*6] |-> !link_doe)
    else $error("data pin driven outside frame");
endmodule
bind epm_top epm_properties #(
  .COLD_ACT_CYC(COLD_ACT_CYC),
  .WAKE_LP_CYC(WAKE_LP_CYC),
  .PWM_CYC(PWM_CYC)
) props_i (
  .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .link_cs, .link_doe, .pwm_out, .angle_valid, .irq
);
`default_nettype wire

// *** sim/epm_host.sv ***
// Host model: frames link commands and reads replies.
// Assumes core_clk pacing; link clock stands low between frames.
`timescale 1ns/100ps
`default_nettype none
module epm_host (
  input  wire logic core_clk,
  input  wire logic link_dout,
  input  wire logic link_doe,
  output logic      link_clk,
  output logic      link_cs,
  output logic      link_din
);
  logic [15:0] rx;
  // Idle link
  initial begin
    link_clk = 1'b0;
    link_cs  = 1'b0;
    link_din = 1'b1;
  end
  // Four core cycles per half: 80 ns link clock
  task automatic half();
    repeat (4) @(posedge core_clk);
  endtask
  // Command then data MSB first; reply taken on rises
  task automatic xfer(input logic [4:0] cmd, input logic [15:0] dat);
    logic [20:0] sh;
    sh = {cmd, dat};
    link_cs <= 1'b1;
    for (int i = 20; i >= 0; i--) begin
      link_din <= sh[i];
      half();
      link_clk <= 1'b1;
      if (i < 16) rx[i] = link_doe ? link_dout : 1'bz;
      half();
      link_clk <= 1'b0;
    end
    half();
    link_cs  <= 1'b0;
    link_din <= ~sh[0]; // Released line shows the inverse
    half();
  endtask
endmodule
`default_nettype wire

// *** sim/encoder_power_mode_control_tb_top.sv ***
// Self-checking bench for the encoder power-mode block.
// Assumes epm_top, epm_host and the bound checker are compiled.
`timescale 1ns/100ps
`default_nettype none
module encoder_power_mode_control_tb_top;
  localparam int WLP = 30;
  localparam int WUL = 60;
  logic        core_clk    = 1'b0;
  logic        reset_n     = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0;
  logic [7:0]  sense_angle = 8'h00;
  logic [5:0]  sense_gain  = 6'h00;
  logic [31:0] seed        = 32'h0000ac12;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, link_clk, link_cs, link_din;
  logic        link_dout, link_doe, pwm_out, angle_valid, irq;
  int          n_fail      = 0;
  int          n_compared  = 0;
  epm_top #(.COLD_ACT_CYC(200), .COLD_AGC_CYC(500), .WAKE_LP_CYC(WLP),
            .WAKE_ULP_CYC(WUL), .PWM_CYC(600)) dut (
    .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .link_clk, .link_cs, .link_din, .link_dout, .link_doe,
    .sense_angle, .sense_gain, .pwm_out, .angle_valid, .irq);
  epm_host host (.core_clk, .link_dout, .link_doe, .link_clk, .link_cs, .link_din);
  // Clock
  always #5 core_clk = ~core_clk;
  // Random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Expected mode field for {deep sleep select, power save}
  function automatic logic [31:0] mode_of(input logic [1:0] k);
    return k[0] ? (k[1] ? 32'h20 : 32'h10) : 32'h0;
  endfunction
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask
  task automatic wait_valid(output int n);
    n = 0;
    while (angle_valid !== 1'b1 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  // High time of one pulse on the angle output, in core cycles
  task automatic pwm_high(output int n);
    n = 0;
    while (pwm_out !== 1'b0) @(posedge core_clk);
    while (pwm_out !== 1'b1) @(posedge core_clk);
    while (pwm_out === 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    chk(32'h0, 32'h1);
    conclude();
  end
  // Main sequence
  initial begin
    int n;
    logic [31:0] f;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    seed = xs(seed);
    sense_gain <= {2'b00, seed[3:0]};
    rdchk(epm_pkg::A_CTRL, 32'h0, 32'hffffffff);
    rdchk(epm_pkg::A_IMASK, 32'h0, 32'hffffffff);
    rdchk(8'h14, 32'h0, 32'hffffffff);
    chk({31'h0, er}, 32'h1);
    $display("test reset done");
    wait_valid(n);
    repeat (3000) @(posedge core_clk);
    rdchk(epm_pkg::A_STAT, 32'h0f, 32'h3f);
    rdchk(epm_pkg::A_ISTAT, 32'h9, 32'h9);
    rdchk(epm_pkg::A_ISTAT, 32'h0, 32'h9);
    rdchk(epm_pkg::A_ANGLE, {18'h0, sense_gain, sense_angle}, 32'hffffffff);
    apb(1'b1, epm_pkg::A_IMASK, 32'h4);
    host.xfer(epm_pkg::CMD_READ, 16'h0);
    repeat (8) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    chk({16'h0, host.rx}, {16'h0, sense_angle, sense_gain, 2'b11});
    rdchk(epm_pkg::A_ISTAT, 32'h4, 32'h4);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, epm_pkg::A_IMASK, 32'h0);
    $display("test cold start and readout done");
    for (int k = 0; k < 4; k++) begin
      host.xfer(epm_pkg::CMD_PWR, {14'h0, k[1:0]});
      if (k == 2) begin
        host.xfer(epm_pkg::CMD_RST, 16'h1);
        host.xfer(epm_pkg::CMD_RST, 16'h0);
      end
      repeat (8) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      rdchk(epm_pkg::A_STAT, mode_of(k[1:0]), 32'h30);
      rdchk(epm_pkg::A_CTRL, {30'h0, k[1:0]}, 32'hf);
    end
    host.xfer(epm_pkg::CMD_PWR, 16'h0);
    host.xfer(epm_pkg::CMD_RST, 16'h1);
    host.xfer(epm_pkg::CMD_RST, 16'h0);
    wait_valid(n);
    rdchk(epm_pkg::A_STAT, 32'h3, 32'h33);
    $display("test mode codes done");
    for (int d = 0; d < 2; d++) begin
      f = {18'h0, sense_gain, sense_angle};
      apb(1'b1, epm_pkg::A_CTRL, {29'h0, 1'b1, d[0], 1'b1});
      seed = xs(seed);
      sense_gain  <= {2'b00, seed[3:0]};
      sense_angle <= {7'h0, ~sense_angle[0]};
      repeat (300) @(posedge core_clk);
      rdchk(epm_pkg::A_ANGLE, f, 32'hffffffff);
      apb(1'b1, epm_pkg::A_CTRL, 32'h4);
      wait_valid(n);
      chk({31'h0, n >= (d ? WUL : WLP)}, 32'h1);
      repeat (2500) @(posedge core_clk);
      rdchk(epm_pkg::A_ANGLE, {18'h0, sense_gain, sense_angle}, 32'hffffffff);
    end
    $display("test sleep and wake done");
    apb(1'b1, epm_pkg::A_CTRL, 32'h0);
    host.xfer(epm_pkg::CMD_PWR, 16'h1);
    host.xfer(epm_pkg::CMD_PWR, 16'h0);
    host.xfer(epm_pkg::CMD_RST, 16'h1);
    host.xfer(epm_pkg::CMD_RST, 16'h0);
    sense_angle <= 8'h02;
    repeat (2500) @(posedge core_clk);
    wait_valid(n);
    rdchk(epm_pkg::A_ANGLE, 32'h2, 32'hff);
    sense_angle <= 8'h01;
    repeat (2500) @(posedge core_clk);
    rdchk(epm_pkg::A_ANGLE, 32'h2, 32'hff);
    host.xfer(epm_pkg::CMD_RST, 16'h2);
    repeat (50) @(posedge core_clk);
    rdchk(epm_pkg::A_ANGLE, 32'h1, 32'hff);
    pwm_high(n);
    chk(n, (32'(sense_angle) + 32'h1) * epm_pkg::PWM_STEP_CYC);
    $display("test dead band done");
    conclude();
  end
endmodule
`default_nettype wire
